// File: design/tcc_pkg.sv
// Shared constants and types for the channel 3 register C capture/compare block
package tcc_pkg;

	// Bus and datapath widths
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned CTRL_W = 4;
	localparam int unsigned REG8_W = 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_IO_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_MODE    = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_GRC     = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_STATUS  = 12'h00c;

	// Reset values
	localparam logic [CTRL_W-1:0] IO_CTRL_RST = 4'h0;
	localparam logic [CNT_W-1:0]  GRC_RST     = 16'h0000;

	// Field positions
	localparam int unsigned MODE_BUF_BIT  = 0;
	localparam int unsigned ST_CAPT_BIT   = 0;
	localparam int unsigned ST_MATCH_BIT  = 1;
	localparam int unsigned ST_PIN_LVL    = 2;
	localparam int unsigned ST_PIN_EN     = 3;
	localparam int unsigned ST_PIN_IN     = 4;

	// Control field of register C
	typedef struct packed {
		logic role_select_bit;
		logic level_or_source_bit;
		logic action_high_bit;
		logic action_low_bit;
	} tcc_ctrl_s;

	// Role of register C
	typedef enum logic [2:0] {
		MODE_OFF    = 3'b000,
		MODE_OC     = 3'b001,
		MODE_IC_PIN = 3'b010,
		MODE_IC_CH4 = 3'b011,
		MODE_BUFFER = 3'b100
	} tcc_mode_e;

	// Pin action at compare match
	typedef enum logic [1:0] {
		ACT_NONE   = 2'b00,
		ACT_LOW    = 2'b01,
		ACT_HIGH   = 2'b10,
		ACT_TOGGLE = 2'b11
	} tcc_act_e;

	// Synchronised pin edges
	typedef struct packed {
		logic rise;
		logic fall;
	} tcc_edge_s;

endpackage : tcc_pkg

// File: design/tcc_sync_edge.sv
// Two-stage pin synchroniser with registered edge pulses
`timescale 1ns/1ps
module tcc_sync_edge (
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// Asynchronous pin
	input  wire logic            pin_i,
	// Synchronised results
	output logic                 level_q,
	output tcc_pkg::tcc_edge_s   edge_q
);

	logic               meta_q;
	logic               prev_q;
	tcc_pkg::tcc_edge_s edge_d;

	// Edges compare the second stage with its delayed copy prev_q, never the first
	always_comb begin
		edge_d.rise = level_q & ~prev_q;
		edge_d.fall = ~level_q & prev_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q  <= 1'h0;
			level_q <= 1'h0;
			prev_q  <= 1'h0;
			edge_q  <= '0;
		end else begin
			meta_q  <= pin_i;
			level_q <= meta_q;
			prev_q  <= level_q;
			edge_q  <= edge_d;
		end
	end

endmodule : tcc_sync_edge

// File: design/tcc_pin_out.sv
// Output-compare pin level register with initial load and match action
`timescale 1ns/1ps
module tcc_pin_out (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Control
	input  wire logic              load_init,
	input  wire logic              init_level,
	input  wire logic              match,
	input  wire tcc_pkg::tcc_act_e act,
	// Pin level
	output logic                   level_q
);

	logic level_d;

	// A new initial level outranks a match in the same cycle
	always_comb begin
		level_d = level_q;
		if (load_init) begin
			level_d = init_level;
		end else if (match) begin
			unique case (act)
				tcc_pkg::ACT_NONE:   level_d = level_q;
				tcc_pkg::ACT_LOW:    level_d = 1'h0;
				tcc_pkg::ACT_HIGH:   level_d = 1'h1;
				tcc_pkg::ACT_TOGGLE: level_d = ~level_q;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= 1'h0;
		end else begin
			level_q <= level_d;
		end
	end

endmodule : tcc_pin_out

// File: design/tcc_top.sv
// Capture/compare control of timer channel 3 general register C, APB slave
`timescale 1ns/1ps
module tcc_top #(
	parameter int unsigned CNT_W = tcc_pkg::CNT_W
) (
	// Clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [tcc_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [tcc_pkg::DATA_W-1:0]  pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic                             pready,
	output logic                             pslverr,
	output logic [tcc_pkg::DATA_W-1:0]       prdata,
	// Timer side, same clock
	input  wire logic [CNT_W-1:0]            channel3_counter,
	input  wire logic                        channel4_count_pulse,
	// Channel pin
	input  wire logic                        channel3_pin_c_i,
	output logic                             channel3_pin_c_o,
	output logic                             channel3_pin_c_oe_n,
	// Event pulses
	output logic                             capture_pulse,
	output logic                             match_pulse
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	tcc_pkg::tcc_ctrl_s              ctrl_q;
	tcc_pkg::tcc_ctrl_s              ctrl_d;
	logic                            buf_en_q;
	logic                            buf_en_d;
	logic [CNT_W-1:0]                grc_q;
	logic [CNT_W-1:0]                grc_d;
	logic                            capt_flag_q;
	logic                            capt_flag_d;
	logic                            match_flag_q;
	logic                            match_flag_d;
	logic                            eq_prev_q;
	logic                            eq_prev_d;
	logic [tcc_pkg::DATA_W-1:0]      prdata_q;
	logic [tcc_pkg::DATA_W-1:0]      prdata_d;
	logic                            capture_q;
	logic                            capture_d;
	logic                            match_q;
	logic                            match_d;
	logic                            pin_oe_n_q;
	logic                            pin_oe_n_d;

	tcc_pkg::tcc_mode_e              mode;
	tcc_pkg::tcc_act_e               act;
	tcc_pkg::tcc_ctrl_s              new_ctrl;
	tcc_pkg::tcc_edge_s              pin_edge;
	logic                            pin_level_in;
	logic                            pin_level_out;
	logic                            setup_ph;
	logic                            access_ph;
	logic                            addr_hit;
	logic                            wr_io_ctrl;
	logic                            wr_mode;
	logic                            wr_grc;
	logic                            wr_status;
	logic                            lane0;
	logic                            lane1;
	logic                            eq_now;
	logic                            capture_evt;
	logic                            load_init;
	logic                            init_level;

	////////////////////////////////////////////////////////////////////////
	// APB decode

	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign lane0     = pstrb[0];
	assign lane1     = pstrb[1];

	always_comb begin
		unique case (paddr)
			tcc_pkg::OFF_IO_CTRL: addr_hit = 1'h1;
			tcc_pkg::OFF_MODE:    addr_hit = 1'h1;
			tcc_pkg::OFF_GRC:     addr_hit = 1'h1;
			tcc_pkg::OFF_STATUS:  addr_hit = 1'h1;
			default:              addr_hit = 1'h0;
		endcase
	end

	// Zero-wait slave: read data is staged during setup
	assign pready  = 1'h1;
	assign pslverr = access_ph & ~addr_hit;
	assign prdata  = prdata_q;

	assign wr_io_ctrl = access_ph & pwrite & (paddr == tcc_pkg::OFF_IO_CTRL) & lane0;
	assign wr_mode    = access_ph & pwrite & (paddr == tcc_pkg::OFF_MODE) & lane0;
	assign wr_grc     = access_ph & pwrite & (paddr == tcc_pkg::OFF_GRC);
	assign wr_status  = access_ph & pwrite & (paddr == tcc_pkg::OFF_STATUS) & lane0;

	////////////////////////////////////////////////////////////////////////
	// Role decode

	always_comb begin
		if (buf_en_q) begin
			mode = tcc_pkg::MODE_BUFFER;
		end else if (!ctrl_q.role_select_bit) begin
			if (ctrl_q.action_high_bit | ctrl_q.action_low_bit) begin
				mode = tcc_pkg::MODE_OC;
			end else begin
				mode = tcc_pkg::MODE_OFF;
			end
		end else if (ctrl_q.level_or_source_bit) begin
			mode = tcc_pkg::MODE_IC_CH4;
		end else begin
			mode = tcc_pkg::MODE_IC_PIN;
		end
	end

	assign act = tcc_pkg::tcc_act_e'({ctrl_q.action_high_bit, ctrl_q.action_low_bit});

	////////////////////////////////////////////////////////////////////////
	// Pin input and capture trigger

	tcc_sync_edge u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_i   (channel3_pin_c_i),
		.level_q (pin_level_in),
		.edge_q  (pin_edge)
	);

	always_comb begin
		capture_evt = 1'h0;
		unique case (mode)
			tcc_pkg::MODE_IC_PIN: begin
				if (ctrl_q.action_high_bit) begin
					capture_evt = pin_edge.rise | pin_edge.fall;
				end else if (ctrl_q.action_low_bit) begin
					capture_evt = pin_edge.fall;
				end else begin
					capture_evt = pin_edge.rise;
				end
			end
			tcc_pkg::MODE_IC_CH4: capture_evt = channel4_count_pulse;
			tcc_pkg::MODE_OFF:    capture_evt = 1'h0;
			tcc_pkg::MODE_OC:     capture_evt = 1'h0;
			tcc_pkg::MODE_BUFFER: capture_evt = 1'h0;
			default:              capture_evt = 1'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Compare match and pin output

	assign eq_now = (channel3_counter == grc_q);

	// Match fires once on entering equality, so a stopped counter does not toggle forever
	always_comb begin
		eq_prev_d = eq_now;
		match_d   = (mode == tcc_pkg::MODE_OC) & eq_now & ~eq_prev_q;
	end

	// Initial level is applied when software writes a compare code
	assign new_ctrl   = tcc_pkg::tcc_ctrl_s'(pwdata[tcc_pkg::CTRL_W-1:0]);
	assign init_level = new_ctrl.level_or_source_bit;
	assign load_init  = wr_io_ctrl & ~new_ctrl.role_select_bit
		& (new_ctrl.action_high_bit | new_ctrl.action_low_bit);

	tcc_pin_out u_pin (
		.pclk       (pclk),
		.presetn    (presetn),
		.load_init  (load_init),
		.init_level (init_level),
		.match      (match_q),
		.act        (act),
		.level_q    (pin_level_out)
	);

	// Driving only in active compare role; buffer mode and capture release the pin
	always_comb begin
		pin_oe_n_d = ~(mode == tcc_pkg::MODE_OC);
	end

	assign channel3_pin_c_o    = pin_level_out;
	assign channel3_pin_c_oe_n = pin_oe_n_q;
	assign capture_pulse       = capture_q;
	assign match_pulse         = match_q;

	////////////////////////////////////////////////////////////////////////
	// Register next values

	always_comb begin
		ctrl_d       = ctrl_q;
		buf_en_d     = buf_en_q;
		grc_d        = grc_q;
		capt_flag_d  = capt_flag_q;
		match_flag_d = match_flag_q;
		capture_d    = capture_evt;
		if (wr_io_ctrl) begin
			ctrl_d = new_ctrl;
		end
		if (wr_mode) begin
			buf_en_d = pwdata[tcc_pkg::MODE_BUF_BIT];
		end
		if (wr_grc) begin
			if (lane0) begin
				grc_d[7:0] = pwdata[7:0];
			end
			if (lane1) begin
				grc_d[CNT_W-1:8] = pwdata[CNT_W-1:8];
			end
		end
		// Capture outranks a software write to the same register
		if (capture_evt) begin
			grc_d = channel3_counter;
		end
		// Write one to clear; a new event in the same cycle wins
		if (wr_status && pwdata[tcc_pkg::ST_CAPT_BIT]) begin
			capt_flag_d = 1'h0;
		end
		if (wr_status && pwdata[tcc_pkg::ST_MATCH_BIT]) begin
			match_flag_d = 1'h0;
		end
		if (capture_evt) begin
			capt_flag_d = 1'h1;
		end
		if (match_q) begin
			match_flag_d = 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data staging

	always_comb begin
		prdata_d = prdata_q;
		if (setup_ph) begin
			prdata_d = '0;
			if (!pwrite) begin
				unique case (paddr)
					tcc_pkg::OFF_IO_CTRL: begin
						prdata_d[tcc_pkg::CTRL_W-1:0] = ctrl_q;
					end
					tcc_pkg::OFF_MODE: begin
						prdata_d[tcc_pkg::MODE_BUF_BIT] = buf_en_q;
					end
					tcc_pkg::OFF_GRC: begin
						prdata_d[CNT_W-1:0] = grc_q;
					end
					tcc_pkg::OFF_STATUS: begin
						prdata_d[tcc_pkg::ST_CAPT_BIT]  = capt_flag_q;
						prdata_d[tcc_pkg::ST_MATCH_BIT] = match_flag_q;
						prdata_d[tcc_pkg::ST_PIN_LVL]   = pin_level_out;
						prdata_d[tcc_pkg::ST_PIN_EN]    = ~pin_oe_n_q;
						prdata_d[tcc_pkg::ST_PIN_IN]    = pin_level_in;
					end
					default: begin
						prdata_d = '0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q       <= tcc_pkg::IO_CTRL_RST;
			buf_en_q     <= 1'h0;
			grc_q        <= tcc_pkg::GRC_RST;
			capt_flag_q  <= 1'h0;
			match_flag_q <= 1'h0;
			eq_prev_q    <= 1'h1;
			prdata_q     <= '0;
			capture_q    <= 1'h0;
			match_q      <= 1'h0;
			pin_oe_n_q   <= 1'h1;
		end else begin
			ctrl_q       <= ctrl_d;
			buf_en_q     <= buf_en_d;
			grc_q        <= grc_d;
			capt_flag_q  <= capt_flag_d;
			match_flag_q <= match_flag_d;
			eq_prev_q    <= eq_prev_d;
			prdata_q     <= prdata_d;
			capture_q    <= capture_d;
			match_q      <= match_d;
			pin_oe_n_q   <= pin_oe_n_d;
		end
	end

endmodule : tcc_top

// File: tb/tcc_assertions.sv
// Checker of pin control and capture timing for register C
`timescale 1ns/1ps
module tcc_assertions (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Bus writes
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	// Pin and events
	input wire logic        channel4_count_pulse,
	input wire logic        channel3_pin_c_i,
	input wire logic        channel3_pin_c_o,
	input wire logic        channel3_pin_c_oe_n,
	input wire logic        capture_pulse,
	input wire logic        match_pulse
);
	logic [3:0] c_q;
	logic       b_q;
	wire        wr = psel && penable && pwrite && pstrb[0];
	wire        oc_on = !c_q[3] && c_q[1:0] != 2'h0 && !b_q;
	wire        pin_cap = c_q[3:2] == 2'h2 && !b_q;
	// Mirror of the control field and buffer bit, updated as the bus writes them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_q <= 4'h0;
			b_q <= 1'b0;
		end else begin
			if (wr && paddr == 12'h000)
				c_q <= pwdata[3:0];
			if (wr && paddr == 12'h004)
				b_q <= pwdata[0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_oe_follows: assert property ($stable({c_q, b_q})
		|=> channel3_pin_c_oe_n != $past(oc_on)) else $error("pin enable wrong");
	a_init_level: assert property (wr && paddr == 12'h000 && !pwdata[3]
		&& pwdata[1:0] != 2'h0 && !b_q |=> channel3_pin_c_o == $past(pwdata[2]))
		else $error("initial level wrong");
	a_match_low: assert property (match_pulse && !c_q[3] && c_q[1:0] == 2'h1
		|=> !channel3_pin_c_o) else $error("match low wrong");
	a_match_high: assert property (match_pulse && !c_q[3] && c_q[1:0] == 2'h2
		|=> channel3_pin_c_o) else $error("match high wrong");
	a_match_toggle: assert property (match_pulse && oc_on && c_q[1:0] == 2'h3
		|=> channel3_pin_c_o != $past(channel3_pin_c_o)) else $error("toggle wrong");
	a_pin_capture: assert property (pin_cap && ($rose(channel3_pin_c_i) && c_q != 4'h9
		|| $fell(channel3_pin_c_i) && c_q != 4'h8) |-> ##[3:5] capture_pulse)
		else $error("pin capture missing");
	a_ch4_capture: assert property (c_q[3:2] == 2'h3 && !b_q && channel4_count_pulse
		|=> capture_pulse) else $error("count capture missing");
	a_buffer_quiet: assert property (b_q && $past(b_q)
		|-> !capture_pulse && !match_pulse) else $error("event in buffer mode");
endmodule : tcc_assertions

bind tcc_top tcc_assertions i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .channel4_count_pulse, .channel3_pin_c_i, .channel3_pin_c_o,
	.channel3_pin_c_oe_n, .capture_pulse, .match_pulse);

// File: tb/tcc_far_side.sv
// Far-side model: external pin driver and neighbouring channel count clock
`timescale 1ns/1ps
module tcc_far_side (
	// Clock and device pin
	input  wire logic pclk,
	input  wire logic pin_o,
	input  wire logic oe_n,
	// Towards the device
	output logic      pin_w,
	output logic      count_pulse
);
	logic lvl_q = 1'b0;
	initial count_pulse = 1'b0;
	// Device wins the wire while it drives; else the far driver sets it
	assign pin_w = oe_n ? lvl_q : pin_o;
	task automatic drive(input logic v);
		@(posedge pclk);
		lvl_q <= v;
	endtask : drive
	task automatic count();
		@(posedge pclk);
		count_pulse <= 1'b1;
		@(posedge pclk);
		count_pulse <= 1'b0;
	endtask : count
endmodule : tcc_far_side

// File: tb/timer_channel_io_control_test.sv
// Self-checking bench of the register C capture/compare block
`timescale 1ns/1ps
module timer_channel_io_control_test;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic [15:0] cnt = 16'h0000;
	logic        pready, pslverr, err, pin_o, oe_n, pin_w, ch4, cap, mat;
	logic [31:0] g;
	int          n_errors = 0;
	int          n_checks = 0;

	initial forever #5 pclk = ~pclk;
	tcc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hf), .pready, .pslverr, .prdata, .channel3_counter(cnt),
		.channel4_count_pulse(ch4), .channel3_pin_c_i(pin_w), .channel3_pin_c_o(pin_o),
		.channel3_pin_c_oe_n(oe_n), .capture_pulse(cap), .match_pulse(mat));
	tcc_far_side far (.pclk, .pin_o, .oe_n, .pin_w, .count_pulse(ch4));

	////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		apb(0, 12'h000, 0);
		chk("io_control reset", 0, rd);
		apb(1, 12'h000, 32'hf0);
		apb(0, 12'h000, 0);
		chk("io_control upper", 0, rd);
		apb(0, 12'h040, 0);
		chk("unmapped error", 1, {31'h0, err});
		apb(1, 12'h008, 5);
	endtask : t_regs
	task automatic t_compare();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			apb(1, 12'h000, {29'h0, c});
			repeat (2) @(posedge pclk);
			chk("pin disabled", {31'h0, c[1:0] == 2'h0}, {31'h0, oe_n});
			if (c[1:0] != 2'h0) begin
				chk("initial level", {31'h0, c[2]}, {31'h0, pin_o});
				cnt <= 16'h0005;
				repeat (4) @(posedge pclk);
				g = c[1:0] == 2'h1 ? 0 : c[1:0] == 2'h2 ? 1 : {31'h0, !c[2]};
				chk("match level", g, {31'h0, pin_o});
				cnt <= 16'h0000;
			end
		end
	endtask : t_compare
	task automatic t_capture();
		g = 32'h5;
		apb(1, 12'h000, 0);
		repeat (3) @(posedge pclk);
		for (int c = 8; c < 12; c++) begin
			apb(1, 12'h000, c);
			cnt <= 16'h0a00 + 16'(c);
			far.drive(1'b1);
			repeat (8) @(posedge pclk);
			if (c != 9)
				g = 32'h0a00 + c;
			apb(0, 12'h008, 0);
			chk("rise capture", g, rd);
			cnt <= 16'h0b00 + 16'(c);
			far.drive(1'b0);
			repeat (8) @(posedge pclk);
			if (c != 8)
				g = 32'h0b00 + c;
			far.count();
			repeat (3) @(posedge pclk);
			apb(0, 12'h008, 0);
			chk("fall capture", g, rd);
		end
	endtask : t_capture
	task automatic t_ch4();
		for (int c = 12; c < 16; c++) begin
			apb(1, 12'h000, c);
			cnt <= 16'h0c00 + 16'(c);
			far.count();
			repeat (2) @(posedge pclk);
			apb(0, 12'h008, 0);
			chk("count capture", 32'h0c00 + c, rd);
		end
		g = 32'h0c0f;
		// Both event flags are set by now; write one clears them
		apb(0, 12'h00c, 0);
		chk("event flags set", 3, {30'h0, rd[1:0]});
		apb(1, 12'h00c, 3);
		apb(0, 12'h00c, 0);
		chk("event flags cleared", 0, {30'h0, rd[1:0]});
	endtask : t_ch4
	task automatic t_buffer();
		apb(1, 12'h004, 1);
		apb(1, 12'h000, 8);
		cnt <= 16'hdddd;
		far.drive(1'b1);
		repeat (8) @(posedge pclk);
		far.count();
		apb(0, 12'h008, 0);
		chk("buffer no capture", g, rd);
		apb(1, 12'h000, 1);
		repeat (2) @(posedge pclk);
		chk("buffer pin off", 1, {31'h0, oe_n});
		apb(1, 12'h004, 0);
	endtask : t_buffer

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_compare();
		t_capture();
		t_ch4();
		t_buffer();
		complete_run();
	end
	// Whole run needs well under 2000 cycles
	initial begin
		#50us;
		n_errors++;
		complete_run();
	end
endmodule : timer_channel_io_control_test
